/* hw/csi_sequencer.sv */
// start-up, divider initialization and sysref burst control
// assumes register writes arrive as one-cycle strobes from the serial port
// decoder in the clk_sys domain; trigger inputs are asynchronous pins
`timescale 1ns/100ps
module csi_sequencer
    import csi_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port from the serial decoder
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // external sysref triggers
    input wire logic singleEndedTriggerIn,
    input wire logic secondClockTriggerIn,
    // serial port configuration
    output logic fourWireSelect,
    output logic readEdgeSelect,
    // pll and tuning control
    output logic vcxoTuneForce,
    output logic relockPulse,
    output logic vcoCalPulse,
    output logic divInitPulse,
    output logic divInitBusy,
    output logic secondClockToPllBlocked,
    // output gating
    output logic [7:0] deviceClockEnableFirst,
    output logic [7:0] deviceClockEnableSecond,
    // buffered oscillator output settings in force
    output logic oscOutEnable,
    output logic oscOutStyle,
    output logic [1:0] oscOutAmplitude,
    // sysref pulse train
    output logic sysrefOutput
);

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0] ctrlReg;
    logic [7:0] srefReg;
    logic [7:0] countReg;
    logic [7:0] oscStaged;
    logic [7:0] oscActive;
    logic [7:0] oeFirst;
    logic [7:0] oeSecond;

    // write decode
    wire wrCtrl = regWrite && (regAddr == CSI_REG_CTRL);
    wire wrSref = regWrite && (regAddr == CSI_REG_SREF);
    wire wrCount = regWrite && (regAddr == CSI_REG_COUNT);
    wire wrOsc = regWrite && (regAddr == CSI_REG_OSC);
    wire wrOeFirst = regWrite && (regAddr == CSI_REG_OE_FIRST);
    wire wrOeSecond = regWrite && (regAddr == CSI_REG_OE_SECOND);

    // command requests from this write
    wire reqDivInit = wrCtrl && regWdata[CSI_CTRL_DIV_INIT];
    wire reqRelock = wrCtrl && regWdata[CSI_CTRL_PLL_CMD_A];
    wire reqVcoCal = wrCtrl && regWdata[CSI_CTRL_VCO_CAL];
    wire reqOscUpdate = wrCtrl && regWdata[CSI_CTRL_OSC_UPDATE];
    wire reqStart = wrSref && regWdata[CSI_SREF_START];

    ////////////////////////////////////////////////////////////////////////////
    // divider initialization timer

    localparam logic [15:0] INIT_LAST = 16'(CSI_INIT_CYCLES - 1);
    logic [15:0] initCount;
    logic initBusy;
    wire initDone = initBusy && (initCount == INIT_LAST);

    // a second request while busy restarts the timer so all dividers start together
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            initBusy <= 1'b0;
            initCount <= 16'h0000;
        end else if (reqDivInit) begin
            initBusy <= 1'b1;
            initCount <= 16'h0000;
        end else if (initDone) begin
            initBusy <= 1'b0;
            initCount <= 16'h0000;
        end else if (initBusy) begin
            initCount <= initCount + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger pin synchronisers, a change counts once stages two and three agree

    logic [2:0] seSync;
    logic [2:0] ckSync;
    logic seLevel;
    logic ckLevel;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seSync <= 3'h0;
            ckSync <= 3'h0;
        end else begin
            seSync <= {seSync[1:0], singleEndedTriggerIn};
            ckSync <= {ckSync[1:0], secondClockTriggerIn};
        end
    end

    // filtered levels; edges are taken from these so a glitch cannot fire twice
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seLevel <= 1'b0;
            ckLevel <= 1'b0;
        end else begin
            if (seSync[1] == seSync[2]) begin
                seLevel <= seSync[2];
            end
            if (ckSync[1] == ckSync[2]) begin
                ckLevel <= ckSync[2];
            end
        end
    end

    wire seRise = (seSync[1] == seSync[2]) && seSync[2] && !seLevel;
    wire ckRise = (ckSync[1] == ckSync[2]) && ckSync[2] && !ckLevel;
    wire extSel = srefReg[CSI_SREF_EXT_SEL];
    wire extRise = extSel ? ckRise : seRise;

    ////////////////////////////////////////////////////////////////////////////
    // sysref burst generator

    csi_sr_state_t srState;
    csi_sr_state_t next_srState;
    logic [7:0] pulsesLeft;
    logic [7:0] phaseCount;

    localparam logic [7:0] PERIOD_LAST = 8'(CSI_SREF_PERIOD_CYCLES - 1);
    localparam logic [7:0] HIGH_CYCLES = 8'(CSI_SREF_HIGH_CYCLES);

    wire internalSource = !srefReg[CSI_SREF_SOURCE];
    wire continuousMode = srefReg[CSI_SREF_MODE];
    // internal mode fires at once, external waits for the chosen edge
    wire fireNow = internalSource || extRise;
    wire periodEnd = (phaseCount == PERIOD_LAST);
    wire lastPulse = !continuousMode && (pulsesLeft == 8'h01);

    // next state; a start while running re-arms the burst
    always_comb begin
        next_srState = srState;
        unique case (srState)
            CSI_SR_IDLE: begin
                if (reqStart) begin
                    next_srState = CSI_SR_ARMED;
                end
            end
            CSI_SR_ARMED: begin
                // a start on the launch cycle re-arms, so the start bit is never left set
                if (reqStart) begin
                    next_srState = CSI_SR_ARMED;
                end else if (!initBusy && fireNow) begin
                    next_srState = CSI_SR_RUN;
                end
            end
            CSI_SR_RUN: begin
                if (reqStart) begin
                    next_srState = CSI_SR_ARMED;
                end else if (initBusy || (periodEnd && lastPulse)) begin
                    next_srState = CSI_SR_IDLE;
                end
            end
            default: begin
                next_srState = CSI_SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            srState <= CSI_SR_IDLE;
        end else begin
            srState <= next_srState;
        end
    end

    // pulse phase and remaining count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phaseCount <= 8'h00;
            pulsesLeft <= 8'h00;
        end else if (next_srState != CSI_SR_RUN || srState != CSI_SR_RUN) begin
            phaseCount <= 8'h00;
            pulsesLeft <= countReg;
        end else if (periodEnd) begin
            phaseCount <= 8'h00;
            pulsesLeft <= pulsesLeft - 8'h01;
        end else begin
            phaseCount <= phaseCount + 8'h01;
        end
    end

    // registered pulse output, low from the cycle after initialization starts until it ends
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sysrefOutput <= 1'b0;
        end else begin
            sysrefOutput <= (srState == CSI_SR_RUN) && (next_srState == CSI_SR_RUN)
                            && !initBusy && (phaseCount < HIGH_CYCLES);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register; command bits are one-shot, their pulses issue one cycle after the write

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrlReg <= CSI_CTRL_RESET;
        end else if (wrCtrl) begin
            ctrlReg <= regWdata;
            ctrlReg[CSI_CTRL_PLL_CMD_A] <= 1'b0;
            ctrlReg[CSI_CTRL_VCO_CAL] <= 1'b0;
            ctrlReg[CSI_CTRL_OSC_UPDATE] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            relockPulse <= 1'b0;
            vcoCalPulse <= 1'b0;
            divInitPulse <= 1'b0;
        end else begin
            relockPulse <= reqRelock;
            vcoCalPulse <= reqVcoCal;
            divInitPulse <= reqDivInit;
        end
    end

    // sysref register; start bit stays set only while the burst is armed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            srefReg <= CSI_SREF_RESET;
        end else if (wrSref) begin
            srefReg <= regWdata;
        end else if (srState == CSI_SR_ARMED && next_srState == CSI_SR_RUN) begin
            srefReg[CSI_SREF_START] <= 1'b0;
        end
    end

    // count, staged oscillator settings and output enables
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            countReg <= CSI_COUNT_RESET;
            oscStaged <= CSI_OSC_RESET;
            oeFirst <= CSI_OE_RESET;
            oeSecond <= CSI_OE_RESET;
        end else begin
            if (wrCount) begin
                countReg <= regWdata;
            end
            if (wrOsc) begin
                oscStaged <= regWdata;
            end
            if (wrOeFirst) begin
                oeFirst <= regWdata;
            end
            if (wrOeSecond) begin
                oeSecond <= regWdata;
            end
        end
    end

    // staged oscillator settings take hold only on the update command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            oscActive <= CSI_OSC_RESET;
        end else if (reqOscUpdate) begin
            oscActive <= wrOsc ? regWdata : oscStaged;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            deviceClockEnableFirst <= 8'h00;
            deviceClockEnableSecond <= 8'h00;
        end else begin
            deviceClockEnableFirst <= initBusy ? 8'h00 : oeFirst;
            deviceClockEnableSecond <= initBusy ? 8'h00 : oeSecond;
        end
    end

    assign vcxoTuneForce = ctrlReg[CSI_CTRL_FORCE_TUNE];
    assign fourWireSelect = ctrlReg[CSI_CTRL_FOUR_WIRE];
    assign readEdgeSelect = ctrlReg[CSI_CTRL_READ_EDGE];
    assign divInitBusy = initBusy;
    assign secondClockToPllBlocked = srefReg[CSI_SREF_EXT_SEL];
    assign oscOutEnable = oscActive[CSI_OSC_ENABLE];
    assign oscOutStyle = oscActive[CSI_OSC_STYLE];
    assign oscOutAmplitude = oscActive[CSI_OSC_AMP_LO +: 2];

    // read-back: divider init shows 1 while running, then 0
    wire [7:0] ctrlView = {ctrlReg[7:1], initBusy};
    wire [7:0] readMux = (regAddr == CSI_REG_CTRL) ? ctrlView :
                         (regAddr == CSI_REG_SREF) ? srefReg :
                         (regAddr == CSI_REG_COUNT) ? countReg :
                         (regAddr == CSI_REG_OSC) ? oscStaged :
                         (regAddr == CSI_REG_OE_FIRST) ? oeFirst :
                         (regAddr == CSI_REG_OE_SECOND) ? oeSecond : 8'h00;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= readMux;
        end
    end

endmodule

/* common/csi_pkg.sv */
// constants, register map and types of the clock start-up and sysref sequencer
// assumes a single 200 MHz system clock and a byte-wide register port fed by
// the serial port decoder, which lives outside this block
//
// Contract
// - power-on reset loads every register default
// - tuning voltage forced mid-supply until bit cleared
// - clock and sysref outputs disabled after startup
// - oscillator output on, LVPECL, 750mV after power-up
// - three-wire serial mode unless four-wire bit set
// - divider-init bit syncs dividers, then self-clears
// - outputs held low during divider initialization; the registered gating drops them one cycle after it starts
// - pll_cmd_a and calibration bits self-clear
// - clearing force bit releases tuning voltage
// - start bit arms or restarts pulse burst, self-clears
// - internal source emits pulses on start bit
// - external source waits for next trigger rising edge
// - mode bit picks counted or continuous pulses
// - oscillator settings apply only via update bit
// - select bit picks single-ended or second clock trigger
// - external mode uses same count and repeat settings
package csi_pkg;
    // register offsets
    localparam logic [6:0] CSI_REG_CTRL = 7'h70;
    localparam logic [6:0] CSI_REG_SREF = 7'h71;
    localparam logic [6:0] CSI_REG_COUNT = 7'h72;
    localparam logic [6:0] CSI_REG_OSC = 7'h73;
    localparam logic [6:0] CSI_REG_OE_FIRST = 7'h74;
    localparam logic [6:0] CSI_REG_OE_SECOND = 7'h76;
    // control register fields
    localparam int CSI_CTRL_DIV_INIT = 0;
    localparam int CSI_CTRL_PLL_CMD_A = 1;
    localparam int CSI_CTRL_VCO_CAL = 2;
    localparam int CSI_CTRL_FORCE_TUNE = 3;
    localparam int CSI_CTRL_FOUR_WIRE = 4;
    localparam int CSI_CTRL_READ_EDGE = 5;
    localparam int CSI_CTRL_OSC_UPDATE = 6;
    // sysref register fields
    localparam int CSI_SREF_START = 0;
    localparam int CSI_SREF_SOURCE = 1;
    localparam int CSI_SREF_MODE = 2;
    localparam int CSI_SREF_EXT_SEL = 3;
    // oscillator register fields: bit0 enable, bit1 style, bits 3:2 amplitude
    localparam int CSI_OSC_ENABLE = 0;
    localparam int CSI_OSC_STYLE = 1;
    localparam int CSI_OSC_AMP_LO = 2;
    // values after reset
    localparam logic [7:0] CSI_CTRL_RESET = 8'h08;
    localparam logic [7:0] CSI_SREF_RESET = 8'h00;
    localparam logic [7:0] CSI_COUNT_RESET = 8'h01;
    localparam logic [7:0] CSI_OSC_RESET = 8'h07;
    localparam logic [7:0] CSI_OE_RESET = 8'h00;
    // timing
    localparam int CSI_CLK_PERIOD_PS = 5000;
    localparam int CSI_INIT_TIME_NS = 200;
    localparam int CSI_INIT_CYCLES = (CSI_INIT_TIME_NS * 1000 + CSI_CLK_PERIOD_PS - 1)
                                     / CSI_CLK_PERIOD_PS;
    localparam int CSI_SREF_PERIOD_NS = 80;
    localparam int CSI_SREF_PERIOD_CYCLES = (CSI_SREF_PERIOD_NS * 1000) / CSI_CLK_PERIOD_PS;
    localparam int CSI_SREF_HIGH_CYCLES = CSI_SREF_PERIOD_CYCLES / 2;
    // sysref generator states
    typedef enum logic [1:0] {
        CSI_SR_IDLE = 2'b00,
        CSI_SR_ARMED = 2'b01,
        CSI_SR_RUN = 2'b10
    } csi_sr_state_t;
endpackage

/* testbench/csi_sequencer_asserts.sv */
// checker for the start-up and sysref sequencer, bound onto its ports
// assumes one clk_sys domain and the asynchronous active-high rst
`timescale 1ns/100ps
module csi_sequencer_chk
    import csi_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic regWrite,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWdata,
    // watched outputs
    input wire logic vcxoTuneForce,
    input wire logic fourWireSelect,
    input wire logic relockPulse,
    input wire logic vcoCalPulse,
    input wire logic divInitPulse,
    input wire logic divInitBusy,
    input wire logic [7:0] deviceClockEnableFirst,
    input wire logic oscOutEnable,
    input wire logic sysrefOutput
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] busyCnt;
    wire ctrlWr = regWrite && regAddr == CSI_REG_CTRL;
    wire srefGo = regWrite && regAddr == CSI_REG_SREF && regWdata == 8'h01;
    // busy length; cleared on drop so a later run is measured on its own
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busyCnt <= 8'h00;
        end else begin
            busyCnt <= divInitBusy ? busyCnt + 8'h01 : 8'h00;
        end
    end
    //////////////////////////////////////////////////////////////////
    reset_state_a: assert property (
        $fell(rst) |-> vcxoTuneForce && !fourWireSelect && oscOutEnable
            && deviceClockEnableFirst == 8'h00 && !sysrefOutput)
        else $error("state after reset wrong");
    div_start_a: assert property (
        ctrlWr && regWdata[CSI_CTRL_DIV_INIT] |=> divInitPulse && divInitBusy)
        else $error("divider init not started");
    busy_length_a: assert property (
        $fell(divInitBusy) |-> busyCnt == 8'h28)
        else $error("divider init length wrong");
    cmd_clear_a: assert property (
        ctrlWr |=> relockPulse == $past(regWdata[CSI_CTRL_PLL_CMD_A])
            && vcoCalPulse == $past(regWdata[CSI_CTRL_VCO_CAL])
            ##1 ($past(ctrlWr) || !relockPulse && !vcoCalPulse))
        else $error("command pulse wrong");
    outputs_low_a: assert property (
        divInitBusy |=> deviceClockEnableFirst == 8'h00)
        else $error("clock enabled during init");
    no_sysref_busy_a: assert property (
        divInitBusy [*3] |-> !sysrefOutput)
        else $error("sysref during init");
    tune_follow_a: assert property (
        ctrlWr |=> vcxoTuneForce == $past(regWdata[CSI_CTRL_FORCE_TUNE])
            && fourWireSelect == $past(regWdata[CSI_CTRL_FOUR_WIRE]))
        else $error("control bit not applied");
    tune_hold_a: assert property (
        !ctrlWr |=> $stable(vcxoTuneForce) && $stable(fourWireSelect))
        else $error("control bit moved");
    osc_hold_a: assert property (
        !(ctrlWr && regWdata[CSI_CTRL_OSC_UPDATE]) |=> $stable(oscOutEnable))
        else $error("oscillator changed without update");
    sysref_start_a: assert property (
        srefGo && !divInitBusy |-> ##[2:4] sysrefOutput)
        else $error("internal start gave no pulse");
    sysref_width_a: assert property (
        $rose(sysrefOutput) |-> sysrefOutput [*8] ##1 !sysrefOutput)
        else $error("sysref pulse width wrong");
endmodule
bind csi_sequencer csi_sequencer_chk chk (.clk_sys(clk_sys), .rst(rst), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .vcxoTuneForce(vcxoTuneForce),
    .fourWireSelect(fourWireSelect), .relockPulse(relockPulse), .vcoCalPulse(vcoCalPulse),
    .divInitPulse(divInitPulse), .divInitBusy(divInitBusy),
    .deviceClockEnableFirst(deviceClockEnableFirst), .oscOutEnable(oscOutEnable),
    .sysrefOutput(sysrefOutput));

/* testbench/csi_host_model.sv */
// host model: byte-wide register strobes as the serial decoder issues them
// assumes requests change just after a rising clk_sys edge
`timescale 1ns/100ps
module csi_host_model (
    // clock
    input wire logic clk_sys,
    // register port toward the sequencer
    output logic regWrite,
    output logic regRead,
    output logic [6:0] regAddr,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    // idle port; address and data are inverted when released
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 7'h00;
        regWdata = 8'h00;
    end
    //////////////////////////////////////////////////////////////////
    // one byte per access; pll_cmd_a and init are bits of the same byte, so one transfer can carry both
    task automatic writeReg(input logic [6:0] a, input logic [7:0] d);
        if (a >= 7'h78) begin
            return;
        end
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    // read data is taken one edge after the strobe is sampled
    task automatic readReg(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge clk_sys);
        #1;
        d = regRdata;
    endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench of the start-up and sysref sequencer
// assumes the host model drives the register port and the bench the triggers
`timescale 1ns/100ps
module testbench;
    import csi_pkg::*;
    typedef struct {logic [6:0] addr; logic [7:0] value;} csi_row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] trig = 2'b00;
    logic regWrite, regRead, vcxoTuneForce, fourWireSelect, oscOutEnable, oscOutStyle;
    logic divInitBusy, sysrefOutput, secondClockToPllBlocked, readEdgeSelect;
    logic [6:0] regAddr;
    logic [7:0] regWdata, regRdata, deviceClockEnableFirst, deviceClockEnableSecond, rd;
    logic [1:0] oscOutAmplitude;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    csi_row_t rows [7] = '{'{CSI_REG_CTRL, CSI_CTRL_RESET}, '{CSI_REG_SREF, CSI_SREF_RESET},
        '{CSI_REG_COUNT, CSI_COUNT_RESET}, '{CSI_REG_OSC, CSI_OSC_RESET},
        '{CSI_REG_OE_FIRST, CSI_OE_RESET}, '{CSI_REG_OE_SECOND, CSI_OE_RESET},
        '{7'h75, 8'h00}};
    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;
    csi_host_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
    csi_sequencer dut (.clk_sys(clk_sys), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .singleEndedTriggerIn(trig[0]), .secondClockTriggerIn(trig[1]),
        .fourWireSelect(fourWireSelect), .readEdgeSelect(readEdgeSelect),
        .vcxoTuneForce(vcxoTuneForce),
        .relockPulse(), .vcoCalPulse(), .divInitPulse(), .divInitBusy(divInitBusy),
        .secondClockToPllBlocked(secondClockToPllBlocked),
        .deviceClockEnableFirst(deviceClockEnableFirst),
        .deviceClockEnableSecond(deviceClockEnableSecond), .oscOutEnable(oscOutEnable),
        .oscOutStyle(oscOutStyle), .oscOutAmplitude(oscOutAmplitude),
        .sysrefOutput(sysrefOutput));
    //////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts sysref rising edges over a window of clk_sys cycles
    task automatic countPulses(input int cyc, output int cnt);
        logic prev;
        prev = sysrefOutput;
        cnt = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            cnt += (sysrefOutput && !prev) ? 1 : 0;
            prev = sysrefOutput;
        end
    endtask
    // arms an external burst; the pin not selected must not release it
    task automatic extRun(input logic sel);
        host.writeReg(CSI_REG_SREF, {4'h0, sel, 3'b011});
        trig[!sel] <= 1'b1;
        #1 check(secondClockToPllBlocked, sel);
        countPulses(30, n);
        check(8'(n), 8'h00);
        trig[sel] <= 1'b1;
        countPulses(80, n);
        check(8'(n), 8'h03);
        trig <= 2'b00;
    endtask
    // hang guard, well above the length of the sequence below
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    //////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            host.readReg(rows[i].addr, rd);
            check(rd, rows[i].value);
        end
        check(vcxoTuneForce, 1);
        check(deviceClockEnableFirst | deviceClockEnableSecond, 0);
        check({oscOutAmplitude, oscOutStyle, oscOutEnable}, CSI_OSC_RESET);
        check(fourWireSelect, 0);
        check(readEdgeSelect, 0);
        // start-up order: configure, init, pll_cmd_a with calibration, release tuning
        host.writeReg(CSI_REG_COUNT, 8'h03);
        host.writeReg(CSI_REG_CTRL, 8'h09);
        #1 check(divInitBusy, 1);
        host.readReg(CSI_REG_CTRL, rd);
        check(rd, 8'h09);
        for (n = 0; divInitBusy === 1'b1 && n < 100; n++) begin
            @(posedge clk_sys);
            #1;
        end
        check(n < 100, 1);
        host.writeReg(CSI_REG_CTRL, 8'h0E);
        host.readReg(CSI_REG_CTRL, rd);
        check(rd, 8'h08);
        host.writeReg(CSI_REG_CTRL, 8'h30);
        #1 check(vcxoTuneForce, 0);
        check(fourWireSelect, 1);
        check(readEdgeSelect, 1);
        host.writeReg(CSI_REG_OSC, 8'h02);
        #1 check(oscOutEnable, 1);
        host.writeReg(CSI_REG_CTRL, 8'h40);
        #1 check({oscOutAmplitude, oscOutStyle, oscOutEnable}, 8'h02);
        // outputs only once configuration is done, in writes of their own
        host.writeReg(CSI_REG_OE_FIRST, 8'hA5);
        host.writeReg(CSI_REG_OE_SECOND, 8'h3C);
        host.writeReg(7'h78, 8'hFF);
        @(posedge clk_sys);
        #1 check(deviceClockEnableFirst, 8'hA5);
        check(deviceClockEnableSecond, 8'h3C);
        // two internal counted bursts, each needing its own start
        repeat (2) begin
            host.writeReg(CSI_REG_SREF, 8'h01);
            countPulses(100, n);
            check(8'(n), 8'h03);
        end
        host.readReg(CSI_REG_SREF, rd);
        check(rd, 8'h00);
        // divider change with outputs left on: init blanks them, the start waits
        host.writeReg(CSI_REG_CTRL, 8'h01);
        host.writeReg(CSI_REG_SREF, 8'h01);
        #1 check(deviceClockEnableFirst | deviceClockEnableSecond, 8'h00);
        countPulses(30, n);
        check(8'(n), 8'h00);
        countPulses(120, n);
        check(8'(n), 8'h03);
        host.writeReg(CSI_REG_CTRL, 8'h02);
        #1 check(deviceClockEnableFirst, 8'hA5);
        check(deviceClockEnableSecond, 8'h3C);
        extRun(1'b0);
        extRun(1'b1);
        // continuous train, then a reset in mid-run
        host.writeReg(CSI_REG_SREF, 8'h05);
        countPulses(160, n);
        check(n > 8, 1);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1 check(vcxoTuneForce, 1);
        host.readReg(CSI_REG_COUNT, rd);
        check(rd, CSI_COUNT_RESET);
        finish_test();
    end
endmodule
